// ===== pkg/copg_map.svh
// Named constants for the clock output power gating block
`ifndef COPG_MAP_SVH
`define COPG_MAP_SVH
`define COPG_CLK_MHZ 20
`define COPG_WAKE_MAX_US 3000
`define COPG_LANES 7
`define COPG_L_HOST 0
`define COPG_L_66 1
`define COPG_L_PCI 2
`define COPG_L_PCIF 3
`define COPG_L_APIC 4
`define COPG_L_REF 5
`define COPG_L_USB 6
`define COPG_B_HOST 0
`define COPG_B_66 1
`define COPG_B_PCI 2
`define COPG_B_APIC 3
`define COPG_S_PD 0
`define COPG_S_HOST 1
`define COPG_S_PCI 2
`define COPG_N_HOST 6
`define COPG_N_66 2
`define COPG_N_PCI 5
`define COPG_N_APIC 3
`define COPG_N_REF 2
`define COPG_REF_HALF 2'h2
`define COPG_CNT_ZERO 4'h0
`define COPG_CNT_ONE 4'h1
`define COPG_REF_ZERO 2'h0
`define COPG_REF_ONE 2'h1
`define COPG_WK_ZERO 16'h0000
`define COPG_WK_ONE 16'h0001
`endif

// ===== pkg/copg_pkg.sv
// Types of the clock output power gating block
package copg_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_OFF, ST_WAKE} copg_state_t;
   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      copg_state_t st;
      logic [3:0] cnt;
      logic [1:0] refc;
      logic ref_ph;
      logic usb_ph;
      logic [15:0] wk;
      logic osc;
      logic vco;
   } copg_ctl_t;
   typedef struct packed {
      logic [6:0] en;
      logic [6:0] clk;
   } copg_lane_t;
endpackage : copg_pkg

// ===== pkg/copg_lane_if.sv
// Control to gate path of the clock output block
`timescale 1ns/1ps
`include "copg_map.svh"
interface copg_lane_if (
   input wire logic clk,
   input wire logic rst
);
   logic ce;
   logic force_low;
   logic [`COPG_LANES-1:0] phase_nxt;
   logic [`COPG_LANES-1:0] want;
   logic [`COPG_LANES-1:0] upd;
   logic [`COPG_LANES-1:0] clk_out;
   modport ctl (input clk, rst, clk_out, output ce, force_low, phase_nxt, want, upd);
   modport lane (input clk, rst, ce, force_low, phase_nxt, want, upd, output clk_out);
endinterface : copg_lane_if

// ===== hdl/copg_lane.sv
// Per-lane glitch-free clock gates with registered outputs
`timescale 1ns/1ps
`include "copg_map.svh"
module copg_lane (
   copg_lane_if.lane lif
);
   import copg_pkg::*;

   copg_lane_t r;
   copg_lane_t next_r;

   // Enables move only on the cycles the control side allows
   always_comb begin
      next_r = r;
      if (lif.ce) begin
         for (int i = 0; i < `COPG_LANES; i++) begin
            if (lif.force_low) begin
               next_r.en[i] = 1'b0;
            end else if (lif.upd[i]) begin
               next_r.en[i] = lif.want[i];
            end
         end
         next_r.clk = lif.phase_nxt & next_r.en; // RULE6
      end
   end

   // State register
   always_ff @(posedge lif.clk) begin
      if (lif.rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign lif.clk_out = r.clk;

   default clocking cb @(posedge lif.clk iff lif.ce); endclocking
   default disable iff (lif.rst);

   // A forced cycle must leave every gate output low on the next edge
   a_gate_force_low: assert property ( // RULE13
      lif.force_low |=> (r.clk == '0))
      else $error("gate output high after force low");
endmodule : copg_lane

// ===== hdl/copg_top.sv
// Power-down and stop gating of the system clock outputs
//
// What this block does
// RULE1: Power-down low holds every output low and turns oscillator and VCOs off.
// RULE2: Host stop low holds host and 66 MHz clocks low, others keep running.
// RULE3: Interrupt, reference and 48 MHz clocks ignore host stop; off only in power-down.
// RULE4: PCI stop low holds gated PCI clocks low; free-running PCI unaffected.
// RULE5: Host and 66 MHz clocks stop low and restart with a full high pulse.
// RULE6: Gated PCI clocks stop low and restart with a full high pulse.
// RULE7: Host stop takes effect after one free-running PCI rising edge, both ways.
// RULE8: PCI stop takes effect after exactly one free-running PCI rising edge.
// RULE9: First valid clocks come just over 3 ms after power-down release (60000 wake cycles at 20 MHz, plus sync and PCI edge).
// RULE10: Power-down entry stops outputs within two free-running PCI rising edges.
// RULE11: Power-down input is asynchronous and synchronised before use.
// RULE12: Outputs are driven low and held before VCOs and oscillator turn off.
// RULE13: Power-down forces outputs low on the next internal host clock falling edge.
// RULE14: Both stop inputs are ignored during power-down entry and exit.
// RULE15: Reference and 48 MHz outputs stop low as soon as possible in power-down.
// RULE16: Host stop arrives aligned to PCI edges but is still synchronised inside.
// RULE17: Outside logic drives PCI stop synchronously to the free-running PCI clock.
// RULE18: Each stop input passes a two-stage synchroniser; gates change while low.
`timescale 1ns/1ps
`include "copg_map.svh"
module copg_top #(
   parameter int unsigned WAKE_CYCLES = `COPG_WAKE_MAX_US * `COPG_CLK_MHZ - 1
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic power_down_n_i,
   input wire logic host_stop_n_i,
   input wire logic pci_stop_n_i,
   output logic [`COPG_N_HOST-1:0] host_clock_out_o,
   output logic [`COPG_N_66-1:0] fixed_66mhz_clock_o,
   output logic [`COPG_N_PCI-1:0] gated_pci_clock_o,
   output logic free_running_pci_clock_o,
   output logic [`COPG_N_APIC-1:0] interrupt_ctrl_clock_o,
   output logic [`COPG_N_REF-1:0] ref_clock_o,
   output logic usb_48mhz_clock_o,
   output logic osc_enable_o,
   output logic vco_enable_o
);
   import copg_pkg::*;

   copg_ctl_t r;
   copg_ctl_t next_r;

   // Decoded helpers shared by control and checks
   logic pd_ok;
   logic host_ok;
   logic pci_ok;
   logic phases_on;
   logic pci_edge;
   logic live;
   logic out_any;
   logic [3:0] cnt_nxt;
   logic ref_nxt;
   logic usb_nxt;
   logic [`COPG_LANES-1:0] ph_nxt;
   logic [`COPG_LANES-1:0] want;
   logic [`COPG_LANES-1:0] upd;
   logic force_low;
   logic [15:0] wake_last;

   assign wake_last = WAKE_CYCLES[15:0];

   copg_lane_if lif (
      .clk(clk_sys_i),
      .rst(rst_i)
   );

   // Gates sit in their own module so every clock pin is one flop
   copg_lane u_lane (
      .lif(lif)
   );

   // Synchronised views of the three control inputs
   assign pd_ok = r.sync2[`COPG_S_PD];
   assign host_ok = r.sync2[`COPG_S_HOST];
   assign pci_ok = r.sync2[`COPG_S_PCI];

   // Internal clocks only run while the VCOs are up
   assign phases_on = (r.st != ST_OFF);

   // Next phase of every internal clock
   always_comb begin
      cnt_nxt = r.cnt;
      ref_nxt = r.ref_ph;
      usb_nxt = r.usb_ph;
      if (phases_on) begin
         cnt_nxt = r.cnt + `COPG_CNT_ONE;
         usb_nxt = ~r.usb_ph;
         if (r.refc == `COPG_REF_HALF) begin
            ref_nxt = ~r.ref_ph;
         end
      end else begin
         cnt_nxt = `COPG_CNT_ZERO;
         ref_nxt = 1'b0;
         usb_nxt = 1'b0;
      end
   end

   // Map phases onto lanes; free PCI shares the PCI phase
   always_comb begin
      ph_nxt = '0;
      ph_nxt[`COPG_L_HOST] = cnt_nxt[`COPG_B_HOST];
      ph_nxt[`COPG_L_66] = cnt_nxt[`COPG_B_66];
      ph_nxt[`COPG_L_PCI] = cnt_nxt[`COPG_B_PCI];
      ph_nxt[`COPG_L_PCIF] = cnt_nxt[`COPG_B_PCI];
      ph_nxt[`COPG_L_APIC] = cnt_nxt[`COPG_B_APIC];
      ph_nxt[`COPG_L_REF] = ref_nxt;
      ph_nxt[`COPG_L_USB] = usb_nxt;
   end

   // Rising edge of the free-running PCI clock, the latency reference
   assign pci_edge = cnt_nxt[`COPG_B_PCI] & ~r.cnt[`COPG_B_PCI];

   // Stop inputs matter only in steady running with power-down high
   assign live = (r.st == ST_RUN) && pd_ok; // RULE14

   // Wanted enable per lane
   always_comb begin
      want = '0;
      want[`COPG_L_HOST] = live & host_ok; // RULE2
      want[`COPG_L_66] = live & host_ok; // RULE2
      want[`COPG_L_PCI] = live & pci_ok; // RULE4
      want[`COPG_L_PCIF] = live;
      want[`COPG_L_APIC] = live; // RULE3
      want[`COPG_L_REF] = live; // RULE3
      want[`COPG_L_USB] = live; // RULE3
   end

   // Update windows: stop-driven lanes switch on the PCI rising edge,
   // when host, 66 MHz and PCI phases are all low or just rising
   always_comb begin
      upd = '0;
      upd[`COPG_L_HOST] = pci_edge; // RULE7
      upd[`COPG_L_66] = pci_edge; // RULE5
      upd[`COPG_L_PCI] = pci_edge; // RULE8
      upd[`COPG_L_PCIF] = pci_edge;
      upd[`COPG_L_APIC] = ~ph_nxt[`COPG_L_APIC]; // RULE18
      upd[`COPG_L_REF] = ~ph_nxt[`COPG_L_REF];
      upd[`COPG_L_USB] = ~ph_nxt[`COPG_L_USB];
   end

   // Force all lanes low at the host falling edge after power-down,
   // and keep them low in every other state; ref may be cut short
   assign force_low = (r.st != ST_RUN) || (!pd_ok && !ph_nxt[`COPG_L_HOST]); // RULE13

   // Hand the decisions to the gate module
   assign lif.ce = ce_i;
   assign lif.force_low = force_low; // RULE15
   assign lif.phase_nxt = ph_nxt;
   assign lif.want = want;
   assign lif.upd = upd;

   // Control state: synchronisers, phase dividers, power sequence
   always_comb begin
      next_r = r;
      if (ce_i) begin
         // Two flops per input; stage one feeds stage two only
         next_r.sync1 = {pci_stop_n_i, host_stop_n_i, power_down_n_i}; // RULE11
         next_r.sync2 = r.sync1; // RULE16
         next_r.cnt = cnt_nxt;
         next_r.ref_ph = ref_nxt;
         next_r.usb_ph = usb_nxt;
         if (!phases_on || r.refc == `COPG_REF_HALF) begin
            next_r.refc = `COPG_REF_ZERO;
         end else begin
            next_r.refc = r.refc + `COPG_REF_ONE;
         end
         case (r.st)
            ST_RUN: begin
               // Leave as the forced low lands on the pins
               if (!pd_ok && !ph_nxt[`COPG_L_HOST]) begin
                  next_r.st = ST_DRAIN; // RULE10
               end
            end
            ST_DRAIN: begin
               // Pins are already low; only now drop the oscillators
               next_r.st = ST_OFF;
               next_r.osc = 1'b0; // RULE12
               next_r.vco = 1'b0; // RULE1
            end
            ST_OFF: begin
               if (pd_ok) begin
                  next_r.st = ST_WAKE;
                  next_r.osc = 1'b1;
                  next_r.vco = 1'b1;
                  next_r.wk = `COPG_WK_ZERO;
               end
            end
            ST_WAKE: begin
               // Settling wait of WAKE_CYCLES + 1 cycles, equal to the power-up limit by default
               if (!pd_ok) begin
                  next_r.st = ST_OFF;
                  next_r.osc = 1'b0;
                  next_r.vco = 1'b0;
               end else if (r.wk >= wake_last) begin
                  next_r.st = ST_RUN; // RULE9
               end else begin
                  next_r.wk = r.wk + `COPG_WK_ONE;
               end
            end
            default: begin
               next_r.st = ST_OFF;
            end
         endcase
      end
   end

   // State register; starts powered down until the input is seen high
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         r <= '0;
         r.st <= ST_OFF;
      end else begin
         r <= next_r;
      end
   end

   // Pins come straight from gate flops or control flops
   assign host_clock_out_o = {`COPG_N_HOST{lif.clk_out[`COPG_L_HOST]}};
   assign fixed_66mhz_clock_o = {`COPG_N_66{lif.clk_out[`COPG_L_66]}};
   assign gated_pci_clock_o = {`COPG_N_PCI{lif.clk_out[`COPG_L_PCI]}};
   assign free_running_pci_clock_o = lif.clk_out[`COPG_L_PCIF];
   assign interrupt_ctrl_clock_o = {`COPG_N_APIC{lif.clk_out[`COPG_L_APIC]}};
   assign ref_clock_o = {`COPG_N_REF{lif.clk_out[`COPG_L_REF]}};
   assign usb_48mhz_clock_o = lif.clk_out[`COPG_L_USB];
   assign osc_enable_o = r.osc;
   assign vco_enable_o = r.vco;

   // Any clock pin high
   assign out_any = |lif.clk_out;

   // Checks; a frozen cycle is not a cycle
   default clocking cb @(posedge clk_sys_i iff ce_i); endclocking
   default disable iff (rst_i);

   a_pd_all_off: assert property ( // RULE1
      (r.st == ST_OFF) |-> !out_any && !vco_enable_o && !osc_enable_o)
      else $error("clock or oscillator active in power-down");

   a_host_stop_low: assert property ( // RULE2
      (live && !host_ok && pci_edge) |=> !host_clock_out_o[0] && !fixed_66mhz_clock_o[0]
         ##1 !host_clock_out_o[0])
      else $error("host clock ran while stopped");

   a_apic_free_run: assert property ( // RULE3
      (live && !host_ok && !ph_nxt[`COPG_L_APIC] && !force_low)
      |=> ##1 (interrupt_ctrl_clock_o[0] == r.cnt[`COPG_B_APIC]) || !live)
      else $error("interrupt clock followed host stop");

   a_pci_stop_low: assert property ( // RULE4
      (live && !pci_ok && pci_edge) |=> !gated_pci_clock_o[0] && free_running_pci_clock_o)
      else $error("gated pci ran while stopped");

   a_host_clean: assert property ( // RULE5
      $rose(host_clock_out_o[0]) |-> $rose(r.cnt[`COPG_B_HOST])
         ##1 (!host_clock_out_o[0] && !r.cnt[`COPG_B_HOST]))
      else $error("host clock pulse truncated");

   a_pci_clean: assert property ( // RULE6
      $rose(gated_pci_clock_o[0]) |-> gated_pci_clock_o[0] [*4]
         ##1 !gated_pci_clock_o[0])
      else $error("gated pci pulse not full width");

   a_host_stop_lat: assert property ( // RULE7
      (live && pci_edge) |=> ##1 (host_clock_out_o[0] == $past(host_ok, 2)))
      else $error("host stop latency not one pci edge");

   a_pci_stop_lat: assert property ( // RULE8
      (live && pci_edge) |=> (gated_pci_clock_o[0] == $past(pci_ok)))
      else $error("pci stop latency not one pci edge");

   a_wake_bound: assert property ( // RULE9
      (r.st == ST_WAKE) |-> (r.wk <= wake_last) && !out_any)
      else $error("wake wait overran");

   a_pd_entry_lat: assert property ( // RULE10
      ($fell(pd_ok) && r.st == ST_RUN) |-> ##[1:2] (r.st == ST_DRAIN) && !out_any)
      else $error("power-down entry too slow");

   a_vco_after_low: assert property ( // RULE12
      $fell(vco_enable_o) |-> !out_any && !$past(out_any))
      else $error("vco off before outputs low");

   a_force_falling: assert property ( // RULE13
      $rose(r.st == ST_DRAIN) |-> !r.cnt[`COPG_B_HOST] && $past(r.cnt[`COPG_B_HOST]))
      else $error("force not on host falling edge");

   a_ref_low_fast: assert property ( // RULE15
      ($fell(pd_ok) && r.st == ST_RUN) |-> ##[1:2] !ref_clock_o[0] && !usb_48mhz_clock_o)
      else $error("reference clocks not stopped");

   // Main scenarios
   c_host_stop: cover property (live && !host_ok && pci_edge);
   c_pci_stop: cover property (live && !pci_ok && pci_edge);
   c_pd_entry: cover property ($rose(r.st == ST_OFF));
   c_wake_done: cover property ($rose(r.st == ST_RUN));
endmodule : copg_top

// ===== tb/copg_stop_ctl_model.sv
// Model of the outside control logic that drives the two stop inputs
`timescale 1ns/1ps
module copg_stop_ctl_model (
   input wire logic clk_sys_i,
   input wire logic free_pci_i,
   input wire logic host_req_n_i,
   input wire logic pci_req_n_i,
   output logic host_stop_n_o,
   output logic pci_stop_n_o
);
   logic free_q = 1'b0;
   initial begin
      host_stop_n_o = 1'b1;
      pci_stop_n_o = 1'b1;
   end
   // Requests move only just after a free PCI rise, never in between
   always @(posedge clk_sys_i) begin
      free_q <= free_pci_i;
      if (free_pci_i === 1'b1 && free_q === 1'b0) begin
         host_stop_n_o <= #1 host_req_n_i;
         pci_stop_n_o <= #1 pci_req_n_i;
      end
   end
endmodule : copg_stop_ctl_model

// ===== tb/test_clock_output_power_gating.sv
// Self-checking bench for the clock output power gating block
`timescale 1ns/1ps
`include "copg_map.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_clock_output_power_gating;
   import copg_pkg::*;
   // Short wake count keeps the run brief
   localparam int WAKE = 20;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic pd_n = 1'b0;
   logic host_req_n = 1'b1;
   logic pci_req_n = 1'b1;
   logic host_stop_n;
   logic pci_stop_n;
   logic [`COPG_N_HOST-1:0] host_clk;
   logic [`COPG_N_66-1:0] f66;
   logic [`COPG_N_PCI-1:0] pci_clk;
   logic free_pci;
   logic [`COPG_N_APIC-1:0] apic;
   logic [`COPG_N_REF-1:0] ref_clk;
   logic usb;
   logic osc;
   logic vco;
   int num_errors = 0;
   int num_checks = 0;
   int rc [`COPG_LANES];
   logic [`COPG_LANES-1:0] lv;
   logic [`COPG_LANES-1:0] lv_q;
   logic all_low;
   // One bit per lane, in the lane index order
   assign lv = {usb, ref_clk[0], apic[0], free_pci, pci_clk[0], f66[0], host_clk[0]};
   assign all_low = ~|{host_clk, f66, pci_clk, free_pci, apic, ref_clk, usb};

   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   copg_top #(.WAKE_CYCLES(WAKE)) dut (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .ce_i(1'b1),
      .power_down_n_i(pd_n),
      .host_stop_n_i(host_stop_n),
      .pci_stop_n_i(pci_stop_n),
      .host_clock_out_o(host_clk),
      .fixed_66mhz_clock_o(f66),
      .gated_pci_clock_o(pci_clk),
      .free_running_pci_clock_o(free_pci),
      .interrupt_ctrl_clock_o(apic),
      .ref_clock_o(ref_clk),
      .usb_48mhz_clock_o(usb),
      .osc_enable_o(osc),
      .vco_enable_o(vco)
   );

   copg_stop_ctl_model partner (
      .clk_sys_i(clk_sys_i),
      .free_pci_i(free_pci),
      .host_req_n_i(host_req_n),
      .pci_req_n_i(pci_req_n),
      .host_stop_n_o(host_stop_n),
      .pci_stop_n_o(pci_stop_n)
   );

   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // Sample just after the edge so registered outputs have landed
   task automatic step();
      @(posedge clk_sys_i);
      #1;
      for (int i = 0; i < `COPG_LANES; i++) begin
         if (lv[i] === 1'b1 && lv_q[i] === 1'b0) rc[i]++;
      end
      lv_q = lv;
   endtask : step

   task automatic clr();
      foreach (rc[i]) rc[i] = 0;
   endtask : clr

   task automatic bound_hit(input int n, input int lim);
      if (n >= lim) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, n, lim);
         stop_test();
      end
   endtask : bound_hit

   // Lanes in mask must toggle over 32 cycles, the others stay quiet
   task automatic expect_run(input logic [`COPG_LANES-1:0] mask);
      clr();
      repeat (32) step();
      for (int i = 0; i < `COPG_LANES; i++) begin
         `CHK(rc[i] > 0, mask[i])
      end
   endtask : expect_run

   // Waits for the partner to move a stop input, then for the next free PCI rise
   task automatic to_pci_rise(input logic lvl, input logic host);
      int n;
      n = 0;
      while ((host ? host_stop_n : pci_stop_n) !== lvl && n < 20) begin
         step();
         n++;
      end
      bound_hit(n, 20);
      clr();
      n = 0;
      while (rc[`COPG_L_PCIF] == 0 && n < 20) begin
         step();
         n++;
      end
      bound_hit(n, 20);
   endtask : to_pci_rise

   task automatic hi_width(input int lane, output int w);
      int n;
      n = 0;
      while (lv[lane] !== 1'b1 && n < 40) begin
         step();
         n++;
      end
      bound_hit(n, 40);
      w = 0;
      while (lv[lane] === 1'b1 && w < 40) begin
         step();
         w++;
      end
   endtask : hi_width

   task automatic sc_wake();
      int n;
      n = 0;
      pd_n = 1'b1;
      while (lv[`COPG_L_PCIF] !== 1'b1 && n < WAKE + 40) begin
         step();
         n++;
      end
      bound_hit(n, WAKE + 40);
      `CHK(n <= WAKE + 14, 1'b1)
      `CHK({osc, vco}, 2'b11)
      expect_run(7'h7f);
   endtask : sc_wake

   task automatic sc_host_stop();
      int w;
      host_req_n = 1'b0;
      to_pci_rise(1'b0, 1'b1);
      expect_run(7'b1111100);
      host_req_n = 1'b1;
      to_pci_rise(1'b1, 1'b1);
      `CHK(rc[`COPG_L_HOST], 0)
      step();
      step();
      `CHK(rc[`COPG_L_HOST] > 0, 1'b1)
      hi_width(`COPG_L_66, w);
      `CHK(w, 2)
   endtask : sc_host_stop

   task automatic sc_pci_stop();
      int w;
      pci_req_n = 1'b0;
      to_pci_rise(1'b0, 1'b0);
      `CHK(lv[`COPG_L_PCI], 1'b0)
      expect_run(7'b1111011);
      pci_req_n = 1'b1;
      to_pci_rise(1'b1, 1'b0);
      `CHK(lv[`COPG_L_PCI], 1'b1)
      hi_width(`COPG_L_PCI, w);
      `CHK(w, 4)
   endtask : sc_pci_stop

   // Both stops held low so power-down must win regardless
   task automatic sc_power_down();
      int n;
      host_req_n = 1'b0;
      pci_req_n = 1'b0;
      to_pci_rise(1'b0, 1'b1);
      pd_n = 1'b0;
      n = 0;
      while (osc !== 1'b0 && n < 20) begin
         step();
         n++;
         `CHK(osc === 1'b0 && all_low !== 1'b1, 1'b0)
      end
      bound_hit(n, 20);
      `CHK(n <= 16, 1'b1)
      expect_run(7'h00);
      `CHK({osc, vco, all_low}, 3'b001)
      host_req_n = 1'b1;
      pci_req_n = 1'b1;
      sc_wake();
   endtask : sc_power_down

   initial begin
      lv_q = '0;
      clr();
      repeat (6) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      step();
      `CHK({osc, vco, all_low}, 3'b001)
      sc_wake();
      sc_host_stop();
      sc_pci_stop();
      sc_power_down();
      stop_test();
   end

   // Watchdog against a hang anywhere in the sequence
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      num_errors++;
      stop_test();
   end
endmodule : test_clock_output_power_gating
